// ==== design/ring_event_pkg.sv ====
package ring_event_pkg;

	// Event codes
	localparam logic [7:0] EV_ACK_RING_USE   = 8'h1c;
	localparam logic [7:0] EV_DATA_RING_USE  = 8'h1d;
	localparam logic [7:0] EV_SNOOP_RING_USE = 8'h1e;
	localparam logic [7:0] EV_BOUNCE         = 8'h05;
	localparam logic [7:0] EV_THROTTLE       = 8'h07;
	localparam logic [7:0] EV_STARVE         = 8'h12;
	localparam logic [7:0] EV_ALLOC          = 8'h13;
	localparam logic [7:0] EV_PROBE_RETRY    = 8'h31;
	localparam logic [7:0] EV_PROBE_CREDIT   = 8'h28;

	// Register byte offsets: control 0..3, counter 0..3, filter, status
	localparam logic [5:0] OFS_CTL0    = 6'h00;
	localparam logic [5:0] OFS_CNT0    = 6'h10;
	localparam logic [5:0] OFS_FILTER  = 6'h20;
	localparam logic [5:0] OFS_STATUS  = 6'h24;

	// Control field positions
	localparam int CTL_CODE_LSB = 0;
	localparam int CTL_MASK_LSB = 8;
	localparam int CTL_EN_BIT   = 22;

	// Sub-selection bit positions
	localparam int SEL_UP_EVEN   = 0;
	localparam int SEL_UP_ODD    = 1;
	localparam int SEL_DN_EVEN   = 2;
	localparam int SEL_DN_ODD    = 3;
	localparam int SEL_TARGET    = 6;

	localparam int NUM_COUNTERS  = 4;
	localparam int CNT_W         = 48;
	localparam logic [31:0] CTL_RESET = 32'h0000_0000;
	localparam logic [15:0] NODE_RESET = 16'h0000;

	typedef struct packed {
		logic [3:0] ackRing;     // up-even, up-odd, down-even, down-odd, as seen on cw/ccw
		logic [3:0] dataRing;
		logic [3:0] snoopRing;
	} ring_use_t;

	typedef struct packed {
		logic [4:0] bounce;      // request, ack, data, spare, snoop
		logic       throttle;
		logic [3:0] starve;
		logic [5:0] alloc;
		logic [4:0] probeRetry;  // any, full, addr, spare, credits
		logic       probeCredit;
		logic [15:0] retryNode;
	} ingress_ev_t;

endpackage

// ==== design/ring_ingress_event_select.sv ====
// Our own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
module ring_ingress_event_select (
	input  wire logic                          mclk,
	input  wire logic                          nrst,
	input  wire logic                          rightHalf,
	input  wire ring_event_pkg::ring_use_t     ringUse,
	input  wire ring_event_pkg::ingress_ev_t   ingressEv,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [5:0]                    wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic [31:0]                        wb_dat_o,
	output logic                               wb_ack_o
);

	// Event inputs come from the agent on mclk; no synchroniser needed
	logic [31:0]     ctl [ring_event_pkg::NUM_COUNTERS];
	logic [ring_event_pkg::CNT_W-1:0] cnt [ring_event_pkg::NUM_COUNTERS];
	logic [15:0]     nodeFilter;
	logic [1:0]      inc [ring_event_pkg::NUM_COUNTERS];
	logic            ack;
	logic [31:0]     rdata;

	wire             access  = wb_cyc_i & wb_stb_i & ~ack;
	wire             wrAcc   = access & wb_we_i;
	wire [1:0]       regIdx  = wb_adr_i[3:2];
	wire             hitCtl  = (wb_adr_i[5:4] == 2'b00);
	wire             hitCnt  = (wb_adr_i[5:4] == 2'b01);
	wire             hitFilt = (wb_adr_i == ring_event_pkg::OFS_FILTER);
	wire             hitStat = (wb_adr_i == ring_event_pkg::OFS_STATUS);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// up/down ring orientation per half
	// Ring sources are presented as cw/ccw; the right half swaps them
	function automatic logic [3:0] orient(input logic [3:0] raw, input logic rh);
		return rh ? {raw[1:0], raw[3:2]} : raw;
	endfunction

	wire [3:0] ackDir   = orient(ringUse.ackRing, rightHalf);
	wire [3:0] dataDir  = orient(ringUse.dataRing, rightHalf);
	wire [3:0] snoopDir = orient(ringUse.snoopRing, rightHalf);

	wire nodeMatch = (ingressEv.retryNode == nodeFilter);

	genvar g;
	generate
		for (g = 0; g < ring_event_pkg::NUM_COUNTERS; g++) begin : gCnt
			wire [7:0] code = ctl[g][ring_event_pkg::CTL_CODE_LSB +: 8];
			wire [7:0] mask = ctl[g][ring_event_pkg::CTL_MASK_LSB +: 8];
			wire       en   = ctl[g][ring_event_pkg::CTL_EN_BIT];
			// one up and one down hit at most
			wire ackUp  = |(ackDir[1:0] & mask[1:0]);
			wire ackDn  = |(ackDir[3:2] & mask[3:2]);
			wire datUp  = |(dataDir[1:0] & mask[1:0]);
			wire datDn  = |(dataDir[3:2] & mask[3:2]);
			// snoop ring counts a cycle once
			wire snpHit = |(snoopDir & mask[3:0]);
			// full covers any of three outgoing queues
			wire retry  = |(ingressEv.probeRetry & {mask[4], 1'b0, mask[2:0]});
			// target bit gates the credit retry
			wire credit = ingressEv.probeCredit & mask[0] &
				(~mask[ring_event_pkg::SEL_TARGET] | nodeMatch);
			logic [1:0] sel;
			always_comb begin
				sel = 2'd0;
				case (code)
					ring_event_pkg::EV_ACK_RING_USE:   sel = {1'b0, ackUp} + {1'b0, ackDn};
					ring_event_pkg::EV_DATA_RING_USE:  sel = {1'b0, datUp} + {1'b0, datDn};
					ring_event_pkg::EV_SNOOP_RING_USE: sel = {1'b0, snpHit};
					ring_event_pkg::EV_BOUNCE:
						sel = {1'b0, |(ingressEv.bounce & {mask[4], 1'b0, mask[2:0]})};
					ring_event_pkg::EV_THROTTLE:       sel = {1'b0, ingressEv.throttle};
					ring_event_pkg::EV_STARVE:
						sel = {1'b0, |(ingressEv.starve & mask[3:0])};
					ring_event_pkg::EV_ALLOC:
						sel = {1'b0, |(ingressEv.alloc & {mask[5:4], 1'b0, mask[2:0]} &
							6'h37)};
					ring_event_pkg::EV_PROBE_RETRY:    sel = {1'b0, retry};
					ring_event_pkg::EV_PROBE_CREDIT:   sel = {1'b0, credit};
					default:                           sel = 2'd0;
				endcase
			end
			assign inc[g] = en ? sel : 2'd0;

			// accumulate every cycle; a write wins over the add
			always_ff @(posedge mclk or negedge nrst) begin
				if (!nrst) begin
					cnt[g] <= '0;
					ctl[g] <= ring_event_pkg::CTL_RESET;
				end else begin
					if (wrAcc && hitCnt && regIdx == 2'(g)) begin
						cnt[g] <= {16'h0000, merge(cnt[g][31:0], wb_dat_i, wb_sel_i)};
					end else begin
						cnt[g] <= cnt[g] + ring_event_pkg::CNT_W'(inc[g]);
					end
					if (wrAcc && hitCtl && regIdx == 2'(g)) begin
						ctl[g] <= merge(ctl[g], wb_dat_i, wb_sel_i);
					end
				end
			end

			a_ring_inc_max: assert property (@(posedge mclk) disable iff (!nrst)
				inc[g] <= 2'd2) else $error("increment above two");
			a_single_inc: assert property (@(posedge mclk) disable iff (!nrst)
				(code != ring_event_pkg::EV_ACK_RING_USE &&
				 code != ring_event_pkg::EV_DATA_RING_USE) |-> inc[g] <= 2'd1)
				else $error("single event added two");
			a_cnt_follow: assert property (@(posedge mclk) disable iff (!nrst)
				!(wrAcc && hitCnt) |=> cnt[g] == $past(cnt[g]) + ring_event_pkg::CNT_W'($past(inc[g])))
				else $error("counter missed increment");
			// ack ring both directions count two
			a_ack_two: assert property (@(posedge mclk) disable iff (!nrst)
				(en && code == ring_event_pkg::EV_ACK_RING_USE && mask[3:0] == 4'hf &&
				 (|ringUse.ackRing[1:0]) && (|ringUse.ackRing[3:2])) |-> inc[g] == 2'd2)
				else $error("ack ring count wrong");
			a_snoop_one: assert property (@(posedge mclk) disable iff (!nrst)
				(en && code == ring_event_pkg::EV_SNOOP_RING_USE && mask[3:0] == 4'hf &&
				 |ringUse.snoopRing) |-> inc[g] == 2'd1)
				else $error("snoop count wrong");
			a_target_gate: assert property (@(posedge mclk) disable iff (!nrst)
				(code == ring_event_pkg::EV_PROBE_CREDIT && mask[ring_event_pkg::SEL_TARGET] &&
				 !nodeMatch) |-> inc[g] == 2'd0)
				else $error("target filter ignored");
			a_throttle_cnt: assert property (@(posedge mclk) disable iff (!nrst)
				(en && code == ring_event_pkg::EV_THROTTLE && ingressEv.throttle) |->
				inc[g] == 2'd1) else $error("throttle missed");
			a_starve_mask: assert property (@(posedge mclk) disable iff (!nrst)
				(code == ring_event_pkg::EV_STARVE && mask[3:0] == 4'h0) |-> inc[g] == 2'd0)
				else $error("starve counted unmasked");
			c_ack_double: cover property (@(posedge mclk) disable iff (!nrst)
				code == ring_event_pkg::EV_ACK_RING_USE && inc[g] == 2'd2);
			c_retry_hit: cover property (@(posedge mclk) disable iff (!nrst)
				code == ring_event_pkg::EV_PROBE_RETRY && inc[g] == 2'd1);
			c_target_hit: cover property (@(posedge mclk) disable iff (!nrst)
				code == ring_event_pkg::EV_PROBE_CREDIT && mask[6] && inc[g] == 2'd1);
		end
	endgenerate

	// Filter and bus answer
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			nodeFilter <= ring_event_pkg::NODE_RESET;
		end else if (wrAcc && hitFilt) begin
			nodeFilter <= 16'(merge({16'h0000, nodeFilter}, wb_dat_i, wb_sel_i));
		end
	end

	// Status shows the four live increments
	always_comb begin
		rdata = 32'h0000_0000;
		if (hitCtl) begin
			rdata = ctl[regIdx];
		end else if (hitCnt) begin
			rdata = cnt[regIdx][31:0];
		end else if (hitFilt) begin
			rdata = {16'h0000, nodeFilter};
		end else if (hitStat) begin
			rdata = {24'h000000, inc[3], inc[2], inc[1], inc[0]};
		end
	end

	// Single-cycle ack; unmapped reads give zero, writes dropped
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ack      <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			ack      <= access;
			wb_dat_o <= access ? rdata : 32'h0000_0000;
		end
	end
	assign wb_ack_o = ack;

endmodule

// ==== test/ring_stop_model.sv ====
`timescale 1ns/1ps
module ring_stop_model (
	input  wire logic                   mclk,
	input  wire logic                   run,
	input  wire logic [15:0]            node,
	output ring_event_pkg::ring_use_t   ringUse,
	output ring_event_pkg::ingress_ev_t ingressEv
);
	function automatic logic [3:0] pick();
		logic [3:0] r;
		r = 4'($urandom);
		return {r[3] & r[2], r[3] & ~r[2], r[1] & r[0], r[1] & ~r[0]};
	endfunction

	initial begin
		ringUse = '0;
		ingressEv = '0;
	end

	// Node hits the filter only half the time, so the target qualifier matters
	always @(posedge mclk) begin
		if (run) begin
			ringUse <= {pick(), pick(), pick()};
			ingressEv <= {22'($urandom), ($urandom % 2) ? node : node ^ 16'h0040};
		end else begin
			ringUse <= '0;
			ingressEv <= '0;
		end
	end
endmodule

// ==== test/ring_ingress_event_select_tb.sv ====
`timescale 1ns/1ps
module ring_ingress_event_select_tb;
	logic                        mclk, nrst, rightHalf, cyc, stb, we, run, ack;
	logic [5:0]                  adr;
	logic [31:0]                 dat, datO, q;
	logic [31:0]                 ctl [4];
	logic [15:0]                 node;
	ring_event_pkg::ring_use_t   ru;
	ring_event_pkg::ingress_ev_t ie;
	longint                      expc [4];
	int                          mismatches, comparisons;
	logic [15:0]                 tbl [16] = '{16'h031c, 16'h0c1d, 16'h0f1e, 16'h1705,
		16'h0c1c, 16'h0f1d, 16'hcc1e, 16'h0007, 16'h0f12, 16'h3713, 16'h0213,
		16'h1731, 16'h4128, 16'h0128, 16'h0305, 16'h031e};

	ring_ingress_event_select u_dut (.mclk(mclk), .nrst(nrst), .rightHalf(rightHalf),
		.ringUse(ru), .ingressEv(ie), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(datO), .wb_ack_o(ack));
	ring_stop_model u_far (.mclk(mclk), .run(run), .node(node), .ringUse(ru), .ingressEv(ie));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	function automatic int two(logic [3:0] x, logic rh, logic [7:0] m);
		logic [3:0] y;
		y = rh ? {x[1:0], x[3:2]} : x;
		return int'(|(y[1:0] & m[1:0])) + int'(|(y[3:2] & m[3:2]));
	endfunction

	function automatic int incf(logic [31:0] c, logic rh, ring_event_pkg::ring_use_t u,
			ring_event_pkg::ingress_ev_t e, logic [15:0] nd);
		logic [7:0] m;
		m = c[15:8];
		if (!c[22]) return 0;
		case (c[7:0])
			ring_event_pkg::EV_ACK_RING_USE: return two(u.ackRing, rh, m);
			ring_event_pkg::EV_DATA_RING_USE: return two(u.dataRing, rh, m);
			ring_event_pkg::EV_SNOOP_RING_USE: return int'(two(u.snoopRing, rh, m) > 0);
			ring_event_pkg::EV_BOUNCE: return int'(|(e.bounce & m[4:0] & 5'h17));
			ring_event_pkg::EV_THROTTLE: return int'(e.throttle);
			ring_event_pkg::EV_STARVE: return int'(|(e.starve & m[3:0]));
			ring_event_pkg::EV_ALLOC: return int'(|(e.alloc & m[5:0] & 6'h37));
			ring_event_pkg::EV_PROBE_RETRY: return int'(|(e.probeRetry & m[4:0] & 5'h17));
			ring_event_pkg::EV_PROBE_CREDIT:
				return int'(m[0] & e.probeCredit & (!m[6] || e.retryNode == nd));
			default: return 0;
		endcase
	endfunction

	// every enabled counter adds its increment each cycle
	always @(posedge mclk) begin
		if (nrst) begin
			for (int k = 0; k < 4; k++) begin
				expc[k] += incf(ctl[k], rightHalf, ru, ie, node);
			end
		end
	end

	task automatic wbx(input logic w, input logic [5:0] a, input logic [31:0] d,
			output logic [31:0] r);
		int n;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		r = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50) begin
			mismatches++;
			$display("[FAIL] %0t no bus answer", $time);
		end
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task end_sim();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Ample margin over the roughly 1500 cycles the tests need
	initial begin
		#400000;
		mismatches++;
		end_sim();
	end

	initial begin
		{nrst, rightHalf, cyc, stb, we, run, adr, dat, node} = '0;
		for (int k = 0; k < 4; k++) begin
			ctl[k] = '0;
			expc[k] = 0;
		end
		void'($urandom(81518));
		repeat (20) @(posedge mclk);
		nrst <= 1'b1;
		for (int a = 0; a < 48; a += 4) begin
			wbx(1'b0, 6'(a), 32'h0, q);
			chk(q, 32'h0);
		end
		wbx(1'b1, 6'h2c, 32'hffff_ffff, q);
		wbx(1'b0, 6'h2c, 32'h0, q);
		chk(q, 32'h0);
		for (int t = 0; t < 4; t++) begin
			rightHalf <= t[0];
			node = 16'($urandom);
			wbx(1'b1, ring_event_pkg::OFS_FILTER, {16'h0, node}, q);
			wbx(1'b0, ring_event_pkg::OFS_FILTER, 32'h0, q);
			chk(q, {16'h0, node});
			for (int k = 0; k < 4; k++) begin
				ctl[k] = {9'h0, t != 2 || k != 1, 6'h0, tbl[t * 4 + k]};
				wbx(1'b1, 6'(4 * k), ctl[k], q);
				wbx(1'b0, 6'(4 * k), 32'h0, q);
				chk(q, ctl[k]);
				expc[k] = longint'($urandom);
				wbx(1'b1, 6'(16 + 4 * k), 32'(expc[k]), q);
			end
			run <= 1'b1;
			repeat (300) @(posedge mclk);
			run <= 1'b0;
			repeat (3) @(posedge mclk);
			for (int k = 0; k < 4; k++) begin
				wbx(1'b0, 6'(16 + 4 * k), 32'h0, q);
				chk(q, expc[k][31:0]);
			end
			$display("test %0d done", t);
		end
		end_sim();
	end
endmodule
